// ==== logic/bcm_buck_switch_controller.sv ====
`timescale 1ns/1ns
module bcm_buck_switch_controller
	import bcm_pkg::*;
#(
	parameter int unsigned short_detect_limit = short_detect_cycles,
	parameter int unsigned off_limit = off_limit_cycles,
	parameter int unsigned dim_timeout = dim_timeout_cycles
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic valley_seen,
	input wire logic ring_freq_ok,
	input wire logic ring_swing_ok,
	input wire logic peak_current_threshold,
	input wire logic sense_above_coil_limit,
	input wire logic ramp_threshold,
	input wire logic supply_start_level,
	input wire logic supply_stop_level,
	input wire logic supply_reset_level,
	input wire logic regulator_on_level,
	input wire logic die_hot_threshold,
	input wire logic die_cool_threshold,
	input wire logic temp_below_timer_level,
	input wire logic temp_below_deact_level,
	input wire logic temp_above_high_level,
	input wire logic temp_above_low_level,
	input wire logic alt_supply_present,
	output logic switch_on,
	output logic ramp_charge,
	output logic startup_source_on,
	output logic regulator_on,
	output logic blanking,
	output logic dimmed,
	output logic latched_protect,
	output logic safe_restart,
	output logic supply_lockout,
	output logic short_timer_running
);
	typedef enum logic [3:0] {
		st_lockout = 4'h1,
		st_on = 4'h2,
		st_off = 4'h4,
		st_halt = 4'h8
	} phase_type;

	localparam int unsigned in_count = 17;
	localparam logic [timer_width-1:0] blank_lim = timer_width'(blank_cycles);
	localparam logic [timer_width-1:0] ramp_min_lim = timer_width'(ramp_min_cycles);
	localparam logic [timer_width-1:0] on_lim = timer_width'(on_limit_cycles);
	localparam logic [timer_width-1:0] off_lim = timer_width'(off_limit);
	localparam logic [timer_width-1:0] dim_lim = timer_width'(dim_timeout);
	localparam logic [timer_width-1:0] short_lim = timer_width'(short_detect_limit);

	logic [in_count-1:0] raw_in;
	logic [in_count-1:0] syn;
	// Synchronised copies of the comparator inputs, grouped by what they watch.
	logic valley_s, freq_s, swing_s;
	logic peak_s, coil_s, ramp_s;
	logic start_s, stop_s, rstlvl_s, reg_s, alt_s;
	logic hot_s, cool_s;
	logic tlow_s, tdeact_s, thigh_s, tlo_s;

	phase_type phase_q;
	logic latch_q;
	logic otp_q;
	logic led_otp_q;
	logic dim_q;
	logic ramp_short_q;
	logic short_run_q;
	logic tmr_watch_q;

	logic [timer_width-1:0] phase_count;
	logic switch_on_d;
	logic phase_clear;
	logic short_clear;
	logic short_expired;
	logic dim_expired;
	logic blank_done;
	logic valid_valley;
	logic on_limit_hit;
	logic ramp_hit;
	logic turn_off;
	logic off_timeout;
	logic fault_active;

	assign raw_in = {valley_seen, ring_freq_ok, ring_swing_ok, peak_current_threshold,
		sense_above_coil_limit, ramp_threshold, supply_start_level, supply_stop_level,
		supply_reset_level, regulator_on_level, die_hot_threshold, die_cool_threshold,
		temp_below_timer_level, temp_below_deact_level, temp_above_high_level,
		temp_above_low_level, alt_supply_present};

	// All comparator results cross into the clock domain before use.
	level_sync #(.width(in_count)) u_sync
	(
		.clk(clk),
		.rst(rst),
		.async_in(raw_in),
		.sync_out(syn)
	);

	assign {valley_s, freq_s, swing_s, peak_s, coil_s, ramp_s, start_s, stop_s, rstlvl_s,
		reg_s, hot_s, cool_s, tlow_s, tdeact_s, thigh_s, tlo_s, alt_s} = syn;

	// Phase timer measures blanking, on-time and off-time from the last edge of the switch.
	cycle_timer u_phase_timer
	(
		.clk(clk),
		.rst(rst),
		.clear(phase_clear),
		.run(phase_q == st_on || phase_q == st_off),
		.limit({timer_width{1'b1}}),
		.count(phase_count),
		.expired()
	);

	assign blank_done = phase_count >= blank_lim;
	assign valid_valley = valley_s && freq_s && swing_s;
	assign on_limit_hit = phase_count >= on_lim;
	// A crossing inside the first microsecond is taken as an open or grounded pin.
	assign ramp_hit = ramp_s && !ramp_short_q && phase_count >= ramp_min_lim;
	assign turn_off = (blank_done && peak_s) || on_limit_hit || ramp_hit;
	assign off_timeout = phase_count >= off_lim;
	assign fault_active = latch_q || otp_q || led_otp_q;

	always_comb
	begin
		phase_clear = 1'b0;
		unique case (phase_q)
			st_on: phase_clear = turn_off || (blank_done && coil_s) || dim_q;
			st_off: phase_clear = (valid_valley || off_timeout) && !dim_q;
			st_lockout: phase_clear = 1'b1;
			st_halt: phase_clear = 1'b1;
		endcase
	end

	// Main switching sequencer.
	always_ff @(posedge clk)
	begin
		if (rst)
			phase_q <= st_lockout;
		else if (!stop_s)
			phase_q <= st_lockout;
		else
		begin
			unique case (phase_q)
				// Leaving lockout needs the start level; the lower stop level gives hysteresis.
				st_lockout:
					if (start_s && !fault_active)
						phase_q <= st_off;
				st_on:
					if (fault_active)
						phase_q <= st_halt;
					else if (dim_q || (blank_done && coil_s) || turn_off)
						phase_q <= st_off;
				st_off:
					if (fault_active)
						phase_q <= st_halt;
					else if (!dim_q && (valid_valley || off_timeout))
						phase_q <= st_on;
				st_halt:
					// Wait for the supply to sag below stop, which drops to lockout.
					phase_q <= st_halt;
			endcase
		end
	end

	// Open-pin detection: crossing before 1 us in this on-phase disables the ramp.
	always_ff @(posedge clk)
	begin
		if (rst || phase_q != st_on)
			ramp_short_q <= 1'b0;
		else if (ramp_s && phase_count < ramp_min_lim)
			ramp_short_q <= 1'b1;
	end

	// Shorted coil and output short both set the latch; only a deep supply sag clears it.
	// Setting wins over clearing, so a fault seen while the supply sags is not lost.
	always_ff @(posedge clk)
	begin
		if (rst)
			latch_q <= 1'b0;
		else if (phase_q == st_on && blank_done && coil_s)
			latch_q <= 1'b1;
		else if (short_run_q && short_expired)
			latch_q <= 1'b1;
		else if (!rstlvl_s)
			latch_q <= 1'b0;
	end

	// Die overtemperature holds until the release threshold is passed while the sequencer is in lockout.
	always_ff @(posedge clk)
	begin
		if (rst)
			otp_q <= 1'b0;
		else if (hot_s)
			otp_q <= 1'b1;
		else if (!cool_s && phase_q == st_lockout)
			otp_q <= 1'b0;
	end

	// Temperature pin watch: timer distinguishes dimming from LED overtemperature.
	cycle_timer u_dim_timer
	(
		.clk(clk),
		.rst(rst),
		.clear(!tlow_s),
		.run(tlow_s && !tdeact_s),
		.limit(dim_lim),
		.count(),
		.expired(dim_expired)
	);

	always_ff @(posedge clk)
	begin
		if (rst)
			tmr_watch_q <= 1'b0;
		else
			tmr_watch_q <= tlow_s;
	end

	// Only a pull-down seen before the timer runs out is dimming; a slower one is heat.
	always_ff @(posedge clk)
	begin
		if (rst)
			dim_q <= 1'b0;
		else if (tdeact_s && !dim_expired)
			dim_q <= 1'b1;
		else if (tlo_s)
			dim_q <= 1'b0;
	end

	// Cleared in lockout only, so the converter never restarts into a hot string.
	always_ff @(posedge clk)
	begin
		if (rst)
			led_otp_q <= 1'b0;
		else if (tmr_watch_q && dim_expired && !dim_q)
			led_otp_q <= 1'b1;
		else if (thigh_s && phase_q == st_lockout)
			led_otp_q <= 1'b0;
	end

	// Output-short timer: started on off-time expiry, frozen while dimmed.
	assign short_clear = !stop_s || (phase_q == st_off && valid_valley)
		|| (phase_q == st_on && on_limit_hit && !dim_q);

	// Clearing wins here: below the stop level the timer must start again from zero.
	always_ff @(posedge clk)
	begin
		if (rst || short_clear)
			short_run_q <= 1'b0;
		else if (phase_q == st_off && off_timeout && !valid_valley && !dim_q)
			short_run_q <= 1'b1;
	end

	cycle_timer u_short_timer
	(
		.clk(clk),
		.rst(rst),
		.clear(short_clear || !short_run_q),
		.run(short_run_q && !dim_q),
		.limit(short_lim),
		.count(),
		.expired(short_expired)
	);

	// Supply management outputs.
	always_ff @(posedge clk)
	begin
		if (rst)
			startup_source_on <= 1'b1;
		else
			startup_source_on <= !stop_s || !alt_s;
	end

	// The second regulator also runs in lockout, where it helps the supply climb back.
	always_ff @(posedge clk)
	begin
		if (rst)
			regulator_on <= 1'b0;
		else
			regulator_on <= !reg_s;
	end

	// The switch drops at once on any turn-off cause, a fault or a supply sag.
	always_comb
	begin
		switch_on_d = 1'b0;
		unique case (phase_q)
			st_on: switch_on_d = !phase_clear && !fault_active && stop_s;
			st_off: switch_on_d = 1'b0;
			st_lockout: switch_on_d = 1'b0;
			st_halt: switch_on_d = 1'b0;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			switch_on <= 1'b0;
		else
			switch_on <= switch_on_d;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			blanking <= 1'b0;
		else
			blanking <= (phase_q == st_on) && !blank_done;
	end

	assign ramp_charge = switch_on;
	assign dimmed = dim_q;
	assign latched_protect = latch_q;
	assign safe_restart = otp_q || led_otp_q;
	assign supply_lockout = (phase_q == st_lockout);
	assign short_timer_running = short_run_q;
endmodule // bcm_buck_switch_controller

// ==== logic/bcm_pkg.sv ====
package bcm_pkg;
	localparam int unsigned clk_mhz = 250;
	// Blanking after turn-on, in ns.
	localparam int unsigned blank_ns = 300;
	localparam int unsigned blank_cycles = (blank_ns * clk_mhz + 999) / 1000;
	// Shortest meaningful ramp time, in us; an earlier crossing means an open or grounded pin.
	localparam int unsigned ramp_min_us = 1;
	localparam int unsigned ramp_min_cycles = ramp_min_us * clk_mhz;
	// Internal on-time limit, in us.
	localparam int unsigned on_limit_us = 15;
	localparam int unsigned on_limit_cycles = on_limit_us * clk_mhz;
	// Maximum off-time, in us.
	localparam int unsigned off_limit_us = 50;
	localparam int unsigned off_limit_cycles = off_limit_us * clk_mhz;
	// Output-short detect timeout, in us; long, so the top exposes it as a parameter.
	localparam int unsigned short_detect_us = 1000;
	localparam int unsigned short_detect_cycles = short_detect_us * clk_mhz;
	// Timeout within which a pulled-down temperature pin counts as dimming, in us.
	localparam int unsigned dim_timeout_us = 100;
	localparam int unsigned dim_timeout_cycles = dim_timeout_us * clk_mhz;
	localparam int unsigned timer_width = 20;
	localparam int unsigned sync_stages = 2;
endpackage

// ==== logic/cycle_timer.sv ====
`timescale 1ns/1ns
module cycle_timer
	import bcm_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic clear,
	input wire logic run,
	input wire logic [timer_width-1:0] limit,
	output logic [timer_width-1:0] count,
	output logic expired
);
	// Counts while run is high until it reaches limit; holds otherwise; clear has priority.
	always_ff @(posedge clk)
	begin
		if (rst || clear)
			count <= '0;
		else if (run && count != limit)
			count <= count + 1'b1;
	end

	assign expired = (count == limit);
endmodule // cycle_timer

// ==== logic/level_sync.sv ====
`timescale 1ns/1ns
module level_sync
	import bcm_pkg::*;
#(
	parameter int unsigned width = 1
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [width-1:0] async_in,
	output logic [width-1:0] sync_out
);
	logic [width-1:0] meta_q;

	// The first stage feeds only the second, so no logic sees a metastable value.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			meta_q <= '0;
			sync_out <= '0;
		end
		else
		begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule // level_sync

// ==== tb/bcm_buck_switch_controller_tb_top.sv ====
`timescale 1ns/1ns
module bcm_buck_switch_controller_tb_top;
	import bcm_pkg::*;
	logic clk = 1'h0, rst = 1'h1, supply_start_level = 1'h0, supply_stop_level = 1'h0;
	logic supply_reset_level = 1'h0, regulator_on_level = 1'h0, die_hot_threshold = 1'h0;
	logic die_cool_threshold = 1'h0, temp_below_timer_level = 1'h0, temp_below_deact_level = 1'h0;
	logic temp_above_high_level = 1'h1, temp_above_low_level = 1'h1;
	logic sense_above_coil_limit = 1'h0;
	logic alt_supply_present = 1'h0, ring_good = 1'h0, valley_seen, ring_freq_ok, ring_swing_ok;
	logic peak_current_threshold, ramp_threshold, switch_on, ramp_charge, startup_source_on;
	logic regulator_on, blanking, dimmed, latched_protect, safe_restart, supply_lockout;
	logic short_timer_running;
	int peak_at = 10, ramp_at = 0, valley_at = 0, n = 0, cyc = 0, bad_count = 0, n_compared = 0;
	bcm_buck_switch_controller #(.short_detect_limit(8000), .off_limit(100), .dim_timeout(50)) dut
	(.*);
	switch_stage_model far_side (.*);
	initial forever #2 clk = ~clk;
	// The run needs about 15000 cycles; the ceiling leaves room for slow phases.
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 60000)
		begin
			bad_count++;
			give_verdict();
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// Skips the phase in progress, then measures one whole phase at level lvl.
	task automatic step(input logic lvl, input int lo, input int hi);
		wait (switch_on === !lvl);
		wait (switch_on === lvl);
		n = cyc;
		wait (switch_on === !lvl);
		chk(cyc - n >= lo && cyc - n <= hi, 1);
		@(negedge clk);
	endtask
	task automatic supply(input logic up);
		@(negedge clk);
		{supply_start_level, supply_stop_level, supply_reset_level, regulator_on_level} = {4{up}};
		repeat (10) @(negedge clk);
	endtask
	task automatic give_verdict();
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial
	begin
		repeat (20) @(negedge clk);
		rst = 1'h0;
		repeat (5) @(negedge clk);
		chk(switch_on, 0);
		chk(startup_source_on, 1);
		chk(supply_lockout, 1);
		chk(regulator_on, 1);
		supply(1);
		chk(supply_lockout, 0);
		chk(regulator_on, 0);
		alt_supply_present = 1'h1;
		repeat (5) @(negedge clk);
		chk(startup_source_on, 0);
		alt_supply_present = 1'h0;
		$display("startup test done");
		step(0, 100, 106);
		step(1, 75, 81);
		chk(short_timer_running, 1);
		valley_at = 20;
		ring_good = 1'h1;
		step(0, 20, 26);
		chk(short_timer_running, 0);
		ring_good = 1'h0;
		step(0, 100, 106);
		peak_at = 0;
		ramp_at = 400;
		step(1, 400, 406);
		ramp_at = 100;
		step(1, 3750, 3756);
		chk(short_timer_running, 0);
		$display("timing test done");
		peak_at = 10;
		n = cyc;
		wait (latched_protect === 1'h1);
		@(negedge clk);
		chk(cyc - n > 7900, 1);
		repeat (20) @(negedge clk);
		chk(switch_on, 0);
		chk(latched_protect, 1);
		supply(0);
		chk(latched_protect, 0);
		chk(startup_source_on, 1);
		chk(short_timer_running, 0);
		supply(1);
		$display("output short test done");
		peak_at = 0;
		wait (switch_on === 1'h1);
		@(negedge clk);
		sense_above_coil_limit = 1'h1;
		repeat (50) @(negedge clk);
		chk(latched_protect, 0);
		repeat (40) @(negedge clk);
		chk(latched_protect, 1);
		chk(switch_on, 0);
		sense_above_coil_limit = 1'h0;
		supply(0);
		supply(1);
		$display("shorted coil test done");
		{die_hot_threshold, die_cool_threshold} = 2'h3;
		repeat (10) @(negedge clk);
		chk(safe_restart, 1);
		chk(switch_on, 0);
		die_hot_threshold = 1'h0;
		supply(0);
		supply(1);
		chk(safe_restart, 1);
		die_cool_threshold = 1'h0;
		supply(0);
		supply(1);
		chk(safe_restart, 0);
		peak_at = 10;
		step(1, 75, 81);
		$display("die heat test done");
		{temp_above_high_level, temp_above_low_level, temp_below_timer_level} = 3'h1;
		repeat (10) @(negedge clk);
		temp_below_deact_level = 1'h1;
		repeat (10) @(negedge clk);
		chk(dimmed, 1);
		chk(switch_on, 0);
		chk(safe_restart, 0);
		chk(short_timer_running, 1);
		{temp_above_high_level, temp_above_low_level} = 2'h3;
		{temp_below_timer_level, temp_below_deact_level} = 2'h0;
		step(1, 75, 81);
		chk(dimmed, 0);
		peak_at = 100;
		step(1, 100, 104);
		$display("dimming test done");
		give_verdict();
	end
endmodule // bcm_buck_switch_controller_tb_top

// ==== tb/bcm_ctl_assertions.sv ====
`timescale 1ns/1ns
module bcm_ctl_checker
	import bcm_pkg::*;
#(
	parameter int unsigned off_limit = off_limit_cycles
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic peak_current_threshold,
	input wire logic supply_reset_level,
	input wire logic regulator_on_level,
	input wire logic switch_on,
	input wire logic ramp_charge,
	input wire logic regulator_on,
	input wire logic blanking,
	input wire logic dimmed,
	input wire logic latched_protect,
	input wire logic safe_restart,
	input wire logic supply_lockout
);
	logic [15:0] on_q;
	logic [15:0] off_q;
	logic [7:0] blank_q;
	logic idle;
	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);
	// Off-time counts only while the sequencer may switch, so halts never look like a hang.
	assign idle = !(switch_on || supply_lockout || latched_protect || safe_restart || dimmed);
	always_ff @(posedge clk)
	begin
		on_q <= (rst || !switch_on) ? 16'h0 : on_q + 16'h1;
		off_q <= (rst || !idle) ? 16'h0 : off_q + 16'h1;
		blank_q <= (rst || !blanking) ? 8'h0 : blank_q + 8'h1;
	end
	AST_RAMP: assert property (ramp_charge == switch_on)
		else $error("ramp charge differs from switch state");
	AST_START_FREE: assert property ($rose(switch_on) |->
		!(supply_lockout || latched_protect || safe_restart))
		else $error("switch turned on while halted");
	AST_BLANK_START: assert property ($rose(switch_on) |-> blanking)
		else $error("no blanking at turn-on");
	AST_BLANK_LEN: assert property ($fell(blanking) && switch_on |-> blank_q == blank_cycles)
		else $error("blanking length wrong");
	AST_PEAK_OFF: assert property (
		switch_on && !blanking && peak_current_threshold |-> ##[1:4] !switch_on)
		else $error("peak current did not end the on-phase");
	AST_ON_LIMIT: assert property (on_q <= on_limit_cycles + 4)
		else $error("on-time limit exceeded");
	AST_OFF_LIMIT: assert property (off_q <= off_limit + 6)
		else $error("off-time limit exceeded");
	AST_REG_ON: assert property ($fell(regulator_on_level) |-> ##[1:4] regulator_on)
		else $error("second regulator not started");
	AST_LATCH_CLEAR: assert property (
		latched_protect && $fell(supply_reset_level) |-> ##[1:5] !latched_protect)
		else $error("latch not cleared at low supply");
	AST_LATCH_HOLD: assert property (latched_protect && supply_reset_level |=> latched_protect)
		else $error("latch dropped early");
endmodule // bcm_ctl_checker
bind bcm_buck_switch_controller bcm_ctl_checker #(.off_limit(off_limit)) ctl_chk (.*);

// ==== tb/switch_stage_model.sv ====
`timescale 1ns/1ns
module switch_stage_model
(
	input wire logic clk,
	input wire logic switch_on,
	input wire logic ramp_charge,
	input wire logic ring_good,
	input wire logic signed [31:0] peak_at,
	input wire logic signed [31:0] ramp_at,
	input wire logic signed [31:0] valley_at,
	output logic peak_current_threshold,
	output logic ramp_threshold,
	output logic valley_seen,
	output logic ring_freq_ok,
	output logic ring_swing_ok
);
	int n = 0;
	logic last = 1'h0;
	// Comparators follow the time spent in the present switch state; 0 means never.
	always @(negedge clk)
	begin
		n = (switch_on === last) ? n + 1 : 1;
		last = switch_on;
	end
	assign peak_current_threshold = switch_on && peak_at != 0 && n >= peak_at;
	assign ramp_threshold = ramp_charge && ramp_at != 0 && n >= ramp_at;
	// The ring decays, so a valley is a short pulse rather than a level.
	assign valley_seen = !switch_on && valley_at != 0 && n >= valley_at && n < valley_at + 4;
	assign ring_freq_ok = ring_good;
	assign ring_swing_ok = ring_good;
endmodule // switch_stage_model
